/* File: rtl/pcg_map.svh */
// Purpose: Register offsets, field positions, reset values and counts for the clock generator
// Assumes: Included by bare name from every design file that needs it
// Notes: Word registers on a 4-bit index, 32-bit data
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define PCG_ADDR_CTRL 4'h0
`define PCG_ADDR_BW 4'h1
`define PCG_ADDR_NMUL 4'h2
`define PCG_ADDR_LMUL 4'h3
`define PCG_ADDR_RDIV 4'h4
`define PCG_ADDR_STAT 4'h5
`define PCG_ADDR_CENTER 4'h6

// ************************************************************
// Field positions
// ************************************************************
`define PCG_CTRL_IRQEN 0
`define PCG_CTRL_PON 1
`define PCG_CTRL_BCS 2
`define PCG_CTRL_P_LO 4
`define PCG_CTRL_P_HI 5
`define PCG_CTRL_E_LO 6
`define PCG_CTRL_E_HI 7
`define PCG_BW_AUTO 0
`define PCG_BW_TRK 1
`define PCG_BW_LOCK 2
`define PCG_STAT_ACTIVE 0
`define PCG_STAT_VCOSRC 1
`define PCG_STAT_SWITCH 2

// ************************************************************
// Reset values and counts
// ************************************************************
`define PCG_RST_N 12'h001
`define PCG_RST_L 8'h00
`define PCG_RST_R 4'h1
`define PCG_RST_P 2'h0
`define PCG_RST_E 2'h0
`define PCG_NOMINAL_CENTER_HZ 32'h0000_9600
`define PCG_SWITCH_EDGES 2'h3
`define PCG_TRACK_WINDOWS 4
`define PCG_LOCK_WINDOWS 8

`endif

/* File: rtl/pcg_pkg.sv */
// Purpose: Shared types of the clock generator
// Assumes: Nothing imported; users write pcg_pkg::name
// Notes: Constants live in pcg_map.svh
package pcg_pkg;
   // Base clock selector states
   typedef enum logic [0:0] {
      PCG_SW_RUN,
      PCG_SW_HOLD
   } pcg_sw_state_t;
endpackage : pcg_pkg

/* File: rtl/pcg_pin_sync.sv */
// Purpose: Brings an outside clock or level into clk_in and flags its rising edges
// Assumes: Input toggles well below half of clk_in
// Notes: Level moves only when second and third stages agree
module pcg_pin_sync (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Pin side
   input wire logic pin_in,
   // Filtered level and edge
   output logic level_out,
   output logic rise_out
);
   logic s1; // Metastable stage, read by s2 only
   logic s2; // Second stage
   logic s3; // Third stage

   // ************************************************************
   // Three-stage capture with agreement filter
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         s1 <= 1'h0;
         s2 <= 1'h0;
         s3 <= 1'h0;
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Agreement updates the level; a fresh 0->1 gives one pulse
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         level_out <= 1'h0;
         rise_out <= 1'h0;
      end else begin
         rise_out <= (s2 == s3) && s3 && !level_out;
         if (s2 == s3) begin
            level_out <= s3;
         end
      end
   end
endmodule : pcg_pin_sync

/* File: rtl/pcg_mod_div.sv */
// Purpose: Modulo divider of ticks; one output pulse per modulus ticks
// Assumes: Modulus changes only while cleared
// Notes: A modulus of zero divides by one
module pcg_mod_div #(
   parameter int W = 12
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Control
   input wire logic clear_in,
   input wire logic tick_in,
   input wire logic [W-1:0] modulus_in,
   // Output
   output logic pulse_out,
   output logic level_out
);
   logic [W-1:0] count; // Ticks seen in this period
   logic [W-1:0] last; // Terminal count

   // Zero reads as one, so the terminal count is then zero too
   assign last = (modulus_in == '0) ? '0 : W'(modulus_in - W'(1));

   // ************************************************************
   // Counter, pulse and half-rate level
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || clear_in) begin
         count <= '0;
         pulse_out <= 1'h0;
         level_out <= 1'h0;
      end else begin
         pulse_out <= 1'h0;
         if (tick_in) begin
            if (count >= last) begin
               count <= '0;
               pulse_out <= 1'h1;
               level_out <= !level_out;
            end else begin
               count <= W'(count + W'(1));
            end
         end
      end
   end
endmodule : pcg_mod_div

/* File: rtl/pcg_top.sv */
// Purpose: Digital side of the PLL clock generator: dividers, lock detector, selector, registers
// Assumes: Crystal and VCO clocks arrive as pins well below clk_in/2
// Notes: Reads return data one cycle after the read strobe, zero elsewhere
// How it works
// - Base clock from crystal/2 or VCO/2
// - Oscillator runs on sysint enable or stop-bit
// - Reference clock is buffered crystal clock
// - Reference divided by R for detectors
// - VCO divided by 2^P then N
// - Lock detector compares divided clock frequencies
// - Acquisition mode reads tracking-select as zero
// - Tracking unless acquiring, or tracking-select set
// - Auto mode: detector switches filter mode
// - Auto: tracking-select read-only, follows tolerance
// - Auto: lock flag read-only, follows tolerance
// - Auto with enable: interrupt each lock toggle
// - Manual: written tracking-select picks mode
// - Manual: lock flag off, no interrupts
// - Center frequency is 38.4 kHz times L times 2^E
// - Bus clock is quarter of selected clock
// - R or N of zero acts as one
// - L of zero disables PLL, forces crystal
// - No VCO select while off, no off while selected
// - Hold base clock during source change
`include "pcg_map.svh"
module pcg_top #(
   parameter int TRACK_WINDOWS = `PCG_TRACK_WINDOWS,
   parameter int LOCK_WINDOWS = `PCG_LOCK_WINDOWS
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Register port
   input wire logic [3:0] reg_addr_in,
   input wire logic [31:0] reg_wr_data_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rd_data_out,
   // Oscillator control
   input wire logic osc_enable_from_sysint_in,
   input wire logic osc_run_in_stop_in,
   output logic osc_enable_out,
   // Clock pins from the analog side
   input wire logic crystal_clock_in,
   input wire logic vco_clock_in,
   // Analog controls
   output logic pll_active_out,
   output logic tracking_mode_out,
   output logic [31:0] vco_center_freq_out,
   // Derived clocks
   output logic pll_reference_clock_out,
   output logic divided_reference_clock_out,
   output logic vco_feedback_clock_out,
   output logic base_clock_out,
   output logic bus_clock_out,
   // Interrupt request
   output logic pll_irq_out
);
   // ************************************************************
   // Declarations
   // ************************************************************
   logic pll_irq_enable; // Interrupt enable
   logic pll_power_on; // PLL power request
   logic base_clock_select; // Software wants the VCO
   logic [1:0] p_exp; // Prescaler exponent
   logic [1:0] e_exp; // VCO range exponent
   logic [11:0] n_mul; // Feedback modulus
   logic [7:0] l_mul; // VCO linear range factor
   logic [3:0] r_div; // Reference modulus
   logic auto_bw; // Automatic bandwidth mode
   logic manual_trk; // Written tracking-select
   logic xtal_level; // Filtered crystal level
   logic xtal_rise; // Crystal rising edge
   logic vco_rise; // VCO rising edge
   logic pll_active; // PLL really running
   logic ref_pulse; // Divided reference edge
   logic pre_pulse; // Prescaler output edge
   logic fb_pulse; // Feedback edge
   logic [3:0] pre_mod; // 2^P as a modulus
   logic [1:0] fb_count; // Feedback edges this window, saturating
   logic [7:0] good_run; // Consecutive good windows
   logic det_track; // Detector: within acquisition tolerance
   logic det_lock; // Detector: within lock tolerance
   logic lock_flag; // Registered lock status
   logic track_flag; // Registered tracking status
   logic tracking_select; // Value software reads
   pcg_pkg::pcg_sw_state_t sw_state; // Selector state
   logic vco_source; // Source now driving the base clock
   logic want_vco; // Source asked for
   logic [1:0] old_edges; // Old-source edges during hold
   logic [1:0] new_edges; // New-source edges during hold
   logic src_rise; // Rising edge of the active source
   logic next_pon; // Power-on after a control write
   logic next_bcs; // Select after a control write

   // ************************************************************
   // Oscillator enable and reference
   // ************************************************************
   assign osc_enable_out = osc_enable_from_sysint_in || osc_run_in_stop_in;

   // Crystal clock enters through the pin filter
   pcg_pin_sync u_xtal_sync (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .pin_in(crystal_clock_in),
      .level_out(xtal_level),
      .rise_out(xtal_rise)
   );

   // VCO clock enters the same way
   pcg_pin_sync u_vco_sync (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .pin_in(vco_clock_in),
      .level_out(),
      .rise_out(vco_rise)
   );

   // Reference is a buffered copy of the crystal, same rate
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pll_reference_clock_out <= 1'h0;
      end else begin
         pll_reference_clock_out <= xtal_level;
      end
   end

   // ************************************************************
   // Dividers
   // ************************************************************
   // L of zero keeps the PLL dark whatever power-on says
   assign pll_active = pll_power_on && (l_mul != `PCG_RST_L);
   assign pll_active_out = pll_active;
   assign pre_mod = 4'(4'h1 << p_exp);

   // Reference divider, zero acts as one inside the divider
   pcg_mod_div #(.W(4)) u_ref_div (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .clear_in(!pll_active),
      .tick_in(xtal_rise),
      .modulus_in(r_div),
      .pulse_out(ref_pulse),
      .level_out(divided_reference_clock_out)
   );

   // Power-of-two prescaler on the VCO
   pcg_mod_div #(.W(4)) u_pre_div (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .clear_in(!pll_active),
      .tick_in(vco_rise),
      .modulus_in(pre_mod),
      .pulse_out(pre_pulse),
      .level_out()
   );

   // Modulo N after the prescaler
   pcg_mod_div #(.W(12)) u_fb_div (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .clear_in(!pll_active),
      .tick_in(pre_pulse),
      .modulus_in(n_mul),
      .pulse_out(fb_pulse),
      .level_out(vco_feedback_clock_out)
   );

   // ************************************************************
   // Lock detector
   // ************************************************************
   // One feedback edge per reference period is a good window.
   // Tolerance is a run of good windows; one bad window drops both flags,
   // so a noise hit is seen within one reference period.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !pll_active) begin
         fb_count <= 2'h0;
         good_run <= 8'h00;
         det_track <= 1'h0;
         det_lock <= 1'h0;
      end else if (ref_pulse) begin
         fb_count <= fb_pulse ? 2'h1 : 2'h0;
         if (fb_count == 2'h1) begin
            if (good_run < 8'(LOCK_WINDOWS)) begin
               good_run <= 8'(good_run + 8'h01);
            end
            det_track <= (good_run + 8'h01) >= 8'(TRACK_WINDOWS);
            det_lock <= (good_run + 8'h01) >= 8'(LOCK_WINDOWS);
         end else begin
            good_run <= 8'h00;
            det_track <= 1'h0;
            det_lock <= 1'h0;
         end
      end else if (fb_pulse && fb_count != 2'h3) begin
         fb_count <= 2'(fb_count + 2'h1);
      end
   end

   // Status flags are registered once before software or the irq sees them
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         lock_flag <= 1'h0;
         track_flag <= 1'h0;
      end else begin
         lock_flag <= auto_bw && det_lock;
         track_flag <= det_track;
      end
   end

   // Auto: detector owns the bit; manual: software owns it
   assign tracking_select = auto_bw ? track_flag : manual_trk;
   // Filter is narrow whenever the mode bit says tracking
   assign tracking_mode_out = tracking_select;

   // Interrupt on every lock change, only in auto with enable
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pll_irq_out <= 1'h0;
      end else begin
         pll_irq_out <= auto_bw && pll_irq_enable && (det_lock != lock_flag);
      end
   end

   // ************************************************************
   // Register writes
   // ************************************************************
   // VCO select needs the PLL already on; power-off is refused while selected.
   // Doing both in one write keeps the old select and old power state apart.
   assign next_bcs = reg_wr_data_in[`PCG_CTRL_BCS] && pll_active;
   assign next_pon = reg_wr_data_in[`PCG_CTRL_PON] || base_clock_select;

   // Control register; divider factors frozen while the PLL is on
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pll_irq_enable <= 1'h0;
         pll_power_on <= 1'h0;
         base_clock_select <= 1'h0;
         p_exp <= `PCG_RST_P;
         e_exp <= `PCG_RST_E;
      end else begin
         if (reg_wr_in && reg_addr_in == `PCG_ADDR_CTRL) begin
            pll_irq_enable <= reg_wr_data_in[`PCG_CTRL_IRQEN];
            pll_power_on <= next_pon;
            base_clock_select <= next_bcs;
            if (!pll_power_on) begin
               p_exp <= reg_wr_data_in[`PCG_CTRL_P_HI:`PCG_CTRL_P_LO];
               e_exp <= reg_wr_data_in[`PCG_CTRL_E_HI:`PCG_CTRL_E_LO];
            end
         end else if (!pll_active) begin
            base_clock_select <= 1'h0;
         end
      end
   end

   // Bandwidth register: tracking-select writable only in manual mode
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         auto_bw <= 1'h0;
         manual_trk <= 1'h0;
      end else if (reg_wr_in && reg_addr_in == `PCG_ADDR_BW) begin
         auto_bw <= reg_wr_data_in[`PCG_BW_AUTO];
         if (!reg_wr_data_in[`PCG_BW_AUTO]) begin
            manual_trk <= reg_wr_data_in[`PCG_BW_TRK];
         end
      end
   end

   // Multiplier and divider factors
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         n_mul <= `PCG_RST_N;
         l_mul <= `PCG_RST_L;
         r_div <= `PCG_RST_R;
      end else if (reg_wr_in && !pll_power_on) begin
         if (reg_addr_in == `PCG_ADDR_NMUL) begin
            n_mul <= reg_wr_data_in[11:0];
         end
         if (reg_addr_in == `PCG_ADDR_LMUL) begin
            l_mul <= reg_wr_data_in[7:0];
         end
         if (reg_addr_in == `PCG_ADDR_RDIV) begin
            r_div <= reg_wr_data_in[3:0];
         end
      end
   end

   // Center of range handed to the VCO range logic
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         vco_center_freq_out <= 32'h0000_0000;
      end else begin
         vco_center_freq_out <= 32'(({24'h00_0000, l_mul} << e_exp) * `PCG_NOMINAL_CENTER_HZ);
      end
   end

   // ************************************************************
   // Register reads
   // ************************************************************
   // Data stands only in the cycle after the strobe
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !reg_rd_in) begin
         reg_rd_data_out <= 32'h0000_0000;
      end else begin
         case (reg_addr_in)
            `PCG_ADDR_CTRL: begin
               reg_rd_data_out <= {24'h00_0000, e_exp, p_exp, 1'h0, base_clock_select,
                                   pll_power_on, pll_irq_enable};
            end
            `PCG_ADDR_BW: begin
               reg_rd_data_out <= {29'h0000_0000, lock_flag, tracking_select, auto_bw};
            end
            `PCG_ADDR_NMUL: begin
               reg_rd_data_out <= {20'h0_0000, n_mul};
            end
            `PCG_ADDR_LMUL: begin
               reg_rd_data_out <= {24'h00_0000, l_mul};
            end
            `PCG_ADDR_RDIV: begin
               reg_rd_data_out <= {28'h000_0000, r_div};
            end
            `PCG_ADDR_STAT: begin
               reg_rd_data_out <= {29'h0000_0000, sw_state == pcg_pkg::PCG_SW_HOLD, vco_source,
                                   pll_active};
            end
            `PCG_ADDR_CENTER: begin
               reg_rd_data_out <= vco_center_freq_out;
            end
            default: begin
               reg_rd_data_out <= 32'h0000_0000;
            end
         endcase
      end
   end

   // ************************************************************
   // Base clock selector
   // ************************************************************
   assign want_vco = base_clock_select && pll_active;
   assign src_rise = vco_source ? vco_rise : xtal_rise;

   // Glitch-free change: freeze output until both clocks gave three edges, or the crystal alone when leaving the VCO with the PLL inactive.
   // Costs a few slow crystal periods but never a runt pulse.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         sw_state <= pcg_pkg::PCG_SW_RUN;
         vco_source <= 1'h0;
         old_edges <= 2'h0;
         new_edges <= 2'h0;
      end else begin
         case (sw_state)
            pcg_pkg::PCG_SW_RUN: begin
               old_edges <= 2'h0;
               new_edges <= 2'h0;
               if (want_vco != vco_source) begin
                  sw_state <= pcg_pkg::PCG_SW_HOLD;
               end
            end
            pcg_pkg::PCG_SW_HOLD: begin
               if (src_rise && old_edges != `PCG_SWITCH_EDGES) begin
                  old_edges <= 2'(old_edges + 2'h1);
               end
               if ((vco_source ? xtal_rise : vco_rise) && new_edges != `PCG_SWITCH_EDGES) begin
                  new_edges <= 2'(new_edges + 2'h1);
               end
               // A dead VCO must not trap the crystal, so leaving the VCO with the PLL inactive needs crystal edges only
               if (old_edges == `PCG_SWITCH_EDGES && new_edges == `PCG_SWITCH_EDGES) begin
                  vco_source <= !vco_source;
                  sw_state <= pcg_pkg::PCG_SW_RUN;
               end else if (vco_source && !pll_active && new_edges == `PCG_SWITCH_EDGES) begin
                  vco_source <= 1'h0;
                  sw_state <= pcg_pkg::PCG_SW_RUN;
               end
            end
            default: begin
               sw_state <= pcg_pkg::PCG_SW_RUN;
            end
         endcase
      end
   end

   // Base toggles on each source rise in the run state; bus toggles on each base rise
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         base_clock_out <= 1'h0;
         bus_clock_out <= 1'h0;
      end else if (sw_state == pcg_pkg::PCG_SW_RUN && src_rise) begin
         base_clock_out <= !base_clock_out;
         if (!base_clock_out) begin
            bus_clock_out <= !bus_clock_out;
         end
      end
   end
endmodule : pcg_top

/* File: tb/pcg_top_checker.sv */
// Purpose: Port-level assertions for the clock generator
// Assumes: Pin half periods well above three clk_in cycles
// Notes: Bound into pcg_top at the foot of this file
module pcg_top_checker (
   // Clock, reset and read port
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [31:0] reg_rd_data_out,
   // Oscillator control
   input wire logic osc_enable_from_sysint_in,
   input wire logic osc_run_in_stop_in,
   input wire logic osc_enable_out,
   // Clocks and status
   input wire logic crystal_clock_in,
   input wire logic pll_reference_clock_out,
   input wire logic divided_reference_clock_out,
   input wire logic [31:0] vco_center_freq_out,
   input wire logic base_clock_out,
   input wire logic bus_clock_out,
   input wire logic pll_irq_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // ************
   // Assertions
   // ************
   a_osc_run_or: assert property (osc_enable_out == (osc_enable_from_sysint_in | osc_run_in_stop_in))
      else $error("bad osc enable");
   a_ref_rise_pin: assert property ($rose(pll_reference_clock_out) |-> crystal_clock_in)
      else $error("ref rose, pin low");
   a_ref_fall_pin: assert property ($fell(pll_reference_clock_out) |-> !crystal_clock_in)
      else $error("ref fell, pin high");
   a_divref_on_ref: assert property ($changed(divided_reference_clock_out) |-> pll_reference_clock_out)
      else $error("divref moved off ref rise");
   a_bus_on_base: assert property ($changed(bus_clock_out) |-> base_clock_out)
      else $error("bus moved off base rise");
   a_center_step: assert property (vco_center_freq_out % 38400 == 0)
      else $error("center not nominal multiple");
   a_irq_one_cycle: assert property (pll_irq_out |=> !pll_irq_out)
      else $error("irq too long");
   a_base_steady: assert property ($changed(base_clock_out) |=> $stable(base_clock_out) [*2])
      else $error("base too fast");
   // Main scenarios reached
   c_irq: cover property (pll_irq_out);
   c_bus: cover property ($rose(bus_clock_out));
   c_read: cover property (reg_rd_data_out != 32'h0000_0000);
endmodule : pcg_top_checker

bind pcg_top pcg_top_checker u_pcg_top_checker (
   .clk_in, .sys_rst_in, .reg_rd_data_out, .osc_enable_from_sysint_in, .osc_run_in_stop_in,
   .osc_enable_out, .crystal_clock_in, .pll_reference_clock_out, .divided_reference_clock_out,
   .vco_center_freq_out, .base_clock_out, .bus_clock_out, .pll_irq_out);

/* File: tb/pcg_ext_osc.sv */
// Purpose: Crystal and VCO pin model
// Assumes: Crystal period 200 ns; VCO 200 ns or 260 ns when slowed
// Notes: Pins stand low while stopped
module pcg_ext_osc (
   // Enables
   input wire logic osc_run_in,
   input wire logic vco_run_in,
   input wire logic vco_slow_in,
   // Clock pins
   output logic crystal_clock_out = 1'b0,
   output logic vco_clock_out = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Crystal stops low once its enable drops
   always begin
      #100;
      crystal_clock_out = osc_run_in ? ~crystal_clock_out : 1'b0;
   end
   // VCO runs only while the loop is powered; slowing it breaks lock
   always begin
      #(vco_slow_in ? 130 : 100);
      vco_clock_out = vco_run_in ? ~vco_clock_out : 1'b0;
   end
endmodule : pcg_ext_osc

/* File: tb/test_pll_clock_generator.sv */
// Purpose: Self-checking bench of the clock generator
// Assumes: Register map of pcg_map.svh
// Notes: Clock rates measured in clk_in cycles
`include "pcg_map.svh"
module test_pll_clock_generator;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic sysint = 1'b1;
   logic stop_en = 1'b0;
   logic vco_slow = 1'b0;
   logic [31:0] rdata, center;
   logic osc_en, active, trk, xtal, vco, refclk, divref, fb, base, busclk, irq;
   wire [2:0] mon = {fb, divref, busclk};
   int mismatches = 0, n_compared = 0;
   always #5 clk_in = ~clk_in;
   pcg_top u_pcg_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr), .reg_wr_data_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rd_data_out(rdata), .osc_enable_from_sysint_in(sysint),
      .osc_run_in_stop_in(stop_en), .osc_enable_out(osc_en), .crystal_clock_in(xtal), .vco_clock_in(vco),
      .pll_active_out(active), .tracking_mode_out(trk), .vco_center_freq_out(center),
      .pll_reference_clock_out(refclk), .divided_reference_clock_out(divref), .vco_feedback_clock_out(fb),
      .base_clock_out(base), .bus_clock_out(busclk), .pll_irq_out(irq));
   pcg_ext_osc u_pcg_ext_osc (.osc_run_in(osc_en), .vco_run_in(active), .vco_slow_in(vco_slow),
      .crystal_clock_out(xtal), .vco_clock_out(vco));
   // ************
   // Shared tasks
   // ************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      rd_reg(a, d);
      check(what, d, exp);
   endtask : rd_chk
   // Waits for one interrupt pulse; a hang ends the run
   task automatic wait_irq();
      int i;
      for (i = 0; i < 5000 && irq !== 1'b1; i++) @(negedge clk_in);
      if (i == 5000) begin
         mismatches++;
         finish_test();
      end
   endtask : wait_irq
   // Period between rises of bus clock (0), divided reference (1) or feedback (2)
   task automatic period(input int sel, input int exp, input string what);
      int n = 0;
      int t = 0;
      logic last = 1'b1;
      for (int i = 0; i < 2000 && n < 3; i++) begin
         @(negedge clk_in);
         if (mon[sel] && !last) begin
            n++;
            t = (n == 3) ? i - t : i;
         end
         last = mon[sel];
      end
      check(what, t, exp);
   endtask : period
   // ************
   // Scenarios
   // ************
   task automatic t_reset();
      logic [31:0] exp [8] = '{2: 32'h1, 4: 32'h1, default: 32'h0};
      for (int i = 0; i < 8; i++) rd_chk(i[3:0], exp[i], "reset value");
      wr_reg(4'hF, 32'hFFFF_FFFF);
      rd_chk(4'hF, 32'h0000_0000, "unmapped");
      period(1'b0, 80, "bus period on crystal");
      wr_reg(`PCG_ADDR_RDIV, 32'h0000_0000);
   endtask : t_reset
   task automatic t_osc();
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in);
         sysint <= i[0];
         stop_en <= i[1];
         @(negedge clk_in);
         check("oscillator run", osc_en, i[0] | i[1]);
      end
   endtask : t_osc
   task automatic t_manual();
      wr_reg(`PCG_ADDR_BW, 32'h0000_0002);
      @(negedge clk_in);
      check("manual tracking", trk, 1'b1);
      rd_chk(`PCG_ADDR_BW, 32'h0000_0002, "manual lock off");
      wr_reg(`PCG_ADDR_BW, 32'h0000_0000);
      @(negedge clk_in);
      check("acquisition", trk, 1'b0);
   endtask : t_manual
   task automatic t_refuse();
      wr_reg(`PCG_ADDR_CTRL, 32'h0000_0004);
      rd_chk(`PCG_ADDR_CTRL, 32'h0000_0000, "vco select while off");
      wr_reg(`PCG_ADDR_CTRL, 32'h0000_0002);
      @(negedge clk_in);
      check("active with l zero", active, 1'b0);
      wr_reg(`PCG_ADDR_CTRL, 32'h0000_0000);
      wr_reg(`PCG_ADDR_LMUL, 32'h0000_0002);
      wr_reg(`PCG_ADDR_CTRL, 32'h0000_0042);
      rd_chk(`PCG_ADDR_CENTER, 32'h0002_5800, "center");
      check("active", active, 1'b1);
   endtask : t_refuse
   task automatic t_auto();
      logic [31:0] d = 32'h0;
      wr_reg(`PCG_ADDR_BW, 32'h0000_0003);
      wr_reg(`PCG_ADDR_CTRL, 32'h0000_0043);
      wait_irq();
      rd_chk(`PCG_ADDR_BW, 32'h0000_0007, "locked");
      check("tracking", trk, 1'b1);
      period(1, 40, "divided reference with r zero");
      period(2, 40, "feedback");
      wr_reg(`PCG_ADDR_BW, 32'h0000_0001);
      rd_chk(`PCG_ADDR_BW, 32'h0000_0007, "read only status");
      wr_reg(`PCG_ADDR_CTRL, 32'h0000_0047);
      for (int i = 0; i < 100 && d[1] !== 1'b1; i++) rd_reg(`PCG_ADDR_STAT, d);
      check("vco drives base", d[1], 1'b1);
      wr_reg(`PCG_ADDR_CTRL, 32'h0000_0045);
      rd_chk(`PCG_ADDR_CTRL, 32'h0000_0047, "power off refused");
      @(posedge clk_in);
      vco_slow <= 1'b1;
      wait_irq();
      rd_chk(`PCG_ADDR_BW, 32'h0000_0001, "lock lost");
      period(1'b0, 104, "bus period on vco");
   endtask : t_auto
   initial begin
      repeat (6) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      t_reset();
      t_osc();
      t_manual();
      t_refuse();
      t_auto();
      finish_test();
   end
endmodule : test_pll_clock_generator
